// ### core/dbs_consts.vh
`ifndef DBS_CONSTS_VH
`define DBS_CONSTS_VH

// bits per byte lane on the shared data bus
`define DBS_LANE_W 9
// lanes in the wide and narrow configurations
`define DBS_LANES_WIDE 4
`define DBS_LANES_NARROW 2
// beats per burst, and bits that index a beat
`define DBS_BURST 4
`define DBS_BEAT_W 2
// link edges counted from the command edge (edge 0), half a K cycle each
`define DBS_RD_FIRST_EDGE 5
`define DBS_WR_FIRST_EDGE 2
`define DBS_RD_STAGES 9
`define DBS_WR_STAGES 6
// write buffer
`define DBS_FIFO_DEPTH 8
`define DBS_FIFO_AW 3
// small array by default; each address names one burst of four words
`define DBS_ADDR_W 4

`endif

// ### core/dbs_fifo.v
`timescale 1ns/1ps
`include "dbs_consts.vh"
module dbs_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = `DBS_FIFO_DEPTH,
   parameter AW = `DBS_FIFO_AW
) (
   input wire clk,
   input wire rst,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] count_r;
   wire push;
   wire pop;

   assign in_ready = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != {(AW+1){1'b0}});
   assign out_data = mem_r[rd_ptr_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   function [AW-1:0] ptr_inc;
      input [AW-1:0] p;
      begin
         if (p == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1})
            ptr_inc = {AW{1'b0}};
         else
            ptr_inc = p + {{(AW-1){1'b0}}, 1'b1};
      end
   endfunction

   always @(posedge clk) begin
      if (rst) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            mem_r[wr_ptr_r] <= in_data;
            wr_ptr_r <= ptr_inc(wr_ptr_r);
         end
         if (pop)
            rd_ptr_r <= ptr_inc(rd_ptr_r);
         if (push & ~pop)
            count_r <= count_r + {{AW{1'b0}}, 1'b1};
         else if (pop & ~push)
            count_r <= count_r - {{AW{1'b0}}, 1'b1};
      end
   end
endmodule // dbs_fifo

// ### core/dbs_sram_port.v
// Function
// [R01] An operation begins only on a rising edge of the true input clock, where address and controls are sampled.
// [R02] Every read and write moves exactly four beats at double data rate, with no other burst length.
// [R03] The first read beat leaves two and a half clock cycles after the accepting command edge.
// [R04] Write beats one and three are captured on true-clock rises, beats two and four on complement-clock rises.
// [R05] Read beats one and three launch on complement-clock rises, beats two and four on true-clock rises.
// [R06] Byte-lane enables are sampled with every write beat on both clock phases and may change each beat.
// [R07] The controller presents write beat one a cycle after the command and the next on the following complement rise.
// [R08] Each write completes in the array within two input clock cycles.
// [R09] The first read beat updates on the third complement rise and the second on the fourth true rise.
// [R10] A pair of complementary echo clocks toggles in step with the read data.
// [R11] A valid flag marks each beat in which read data is on the shared bus.
// [R12] Reads and writes share one bus, and the device drives it only during read bursts.
// [R13] The controller spaces commands at least two clock cycles apart.
// [R14] A low load select on a true rise starts an operation, read when read/write select is high, write when low.
// [R15] Each active-low byte-lane enable governs one nine-bit lane, four lanes wide or two narrow.
`timescale 1ns/1ps
`include "dbs_consts.vh"
module dbs_sram_port #(
   parameter LANES = `DBS_LANES_WIDE,
   parameter ADDR_W = `DBS_ADDR_W
) (
   input wire CORE_CLK,
   input wire RESET,
   input wire K,
   input wire K_N,
   input wire LOAD_SELECT_N,
   input wire READ_WRITE_SEL,
   input wire [ADDR_W-1:0] ADDR,
   input wire [LANES-1:0] BYTE_LANE_ENABLE_N,
   input wire [LANES*`DBS_LANE_W-1:0] DQ_IN,
   output wire [LANES*`DBS_LANE_W-1:0] DQ_OUT,
   output wire DQ_OE_N,
   output wire ECHO_CLOCK_TRUE,
   output wire ECHO_CLOCK_COMP,
   output wire READ_VALID_FLAG,
   output wire WR_BUF_READY
);
   localparam DW = LANES * `DBS_LANE_W;
   localparam MW = ADDR_W + `DBS_BEAT_W;
   localparam SW = 4 + ADDR_W + LANES + DW;
   localparam FW = MW + LANES + DW;

   // every pin passes two flops together so that data stays aligned with its clock
   reg [SW-1:0] s1_r;
   reg [SW-1:0] s2_r;
   reg k_d_r;
   reg kn_d_r;
   wire k_s;
   wire kn_s;
   wire ld_n_s;
   wire rw_s;
   wire [ADDR_W-1:0] addr_s;
   wire [LANES-1:0] be_n_s;
   wire [DW-1:0] dq_s;

   always @(posedge CORE_CLK) begin
      if (RESET) begin
         s1_r <= {SW{1'b0}};
         s2_r <= {SW{1'b0}};
         k_d_r <= 1'h0;
         kn_d_r <= 1'h0;
      end else begin
         s1_r <= {K, K_N, LOAD_SELECT_N, READ_WRITE_SEL, ADDR, BYTE_LANE_ENABLE_N, DQ_IN};
         s2_r <= s1_r;
         k_d_r <= k_s;
         kn_d_r <= kn_s;
      end
   end

   assign {k_s, kn_s, ld_n_s, rw_s, addr_s, be_n_s, dq_s} = s2_r;

   wire k_rise = k_s & ~k_d_r;
   wire kn_rise = kn_s & ~kn_d_r;
   wire link_edge = k_rise | kn_rise;
   wire cmd_go = k_rise & ~ld_n_s; // [R01] [R14]
   wire cmd_rd = cmd_go & rw_s; // [R14]
   wire cmd_wr = cmd_go & ~rw_s; // [R14]

   // one stage per link edge; stage 0 is the command edge itself
   reg [`DBS_RD_STAGES-1:0] rd_pipe_r;
   reg [ADDR_W-1:0] rd_addr_r [0:`DBS_RD_STAGES-1];
   reg [`DBS_WR_STAGES-1:0] wr_pipe_r;
   reg [ADDR_W-1:0] wr_addr_r [0:`DBS_WR_STAGES-1];
   integer i;

   always @(posedge CORE_CLK) begin
      if (RESET) begin
         rd_pipe_r <= {`DBS_RD_STAGES{1'b0}};
         wr_pipe_r <= {`DBS_WR_STAGES{1'b0}};
         for (i = 0; i < `DBS_RD_STAGES; i = i + 1)
            rd_addr_r[i] <= {ADDR_W{1'b0}};
         for (i = 0; i < `DBS_WR_STAGES; i = i + 1)
            wr_addr_r[i] <= {ADDR_W{1'b0}};
      end else if (link_edge) begin
         // commands closer than two cycles would overlap bursts on the bus [R13]
         rd_pipe_r <= {rd_pipe_r[`DBS_RD_STAGES-2:0], cmd_rd};
         wr_pipe_r <= {wr_pipe_r[`DBS_WR_STAGES-2:0], cmd_wr};
         rd_addr_r[0] <= addr_s;
         wr_addr_r[0] <= addr_s;
         for (i = 1; i < `DBS_RD_STAGES; i = i + 1)
            rd_addr_r[i] <= rd_addr_r[i-1];
         for (i = 1; i < `DBS_WR_STAGES; i = i + 1)
            wr_addr_r[i] <= wr_addr_r[i-1];
      end
   end

   // array: one word per beat, an address picks a burst of four
   reg [DW-1:0] mem_r [0:(1<<MW)-1];

   // read launch: the entry about to enter stages 5..8 picks beat 0..3
   reg rd_hit;
   reg [MW-1:0] rd_index;
   integer b;
   always @* begin
      rd_hit = 1'b0;
      rd_index = {MW{1'b0}};
      for (b = 0; b < `DBS_BURST; b = b + 1) begin
         if (rd_pipe_r[`DBS_RD_FIRST_EDGE-1+b]) begin // [R02] [R03] [R09]
            rd_hit = 1'b1;
            rd_index = {rd_addr_r[`DBS_RD_FIRST_EDGE-1+b], b[`DBS_BEAT_W-1:0]};
         end
      end
   end

   // write capture: the entry about to enter stages 2..5 takes beat 0..3
   reg wr_hit;
   reg [MW-1:0] wr_index;
   integer c;
   always @* begin
      wr_hit = 1'b0;
      wr_index = {MW{1'b0}};
      for (c = 0; c < `DBS_BURST; c = c + 1) begin
         if (wr_pipe_r[`DBS_WR_FIRST_EDGE-1+c]) begin // [R02] [R07]
            wr_hit = 1'b1;
            wr_index = {wr_addr_r[`DBS_WR_FIRST_EDGE-1+c], c[`DBS_BEAT_W-1:0]};
         end
      end
   end

   // even write beats fall on true rises, even read beats on complement rises, by edge count
   reg [DW-1:0] dq_out_r;
   reg oe_n_r;
   reg valid_r;
   reg echo_t_r;
   reg echo_c_r;

   always @(posedge CORE_CLK) begin
      if (RESET) begin
         dq_out_r <= {DW{1'b0}};
         oe_n_r <= 1'h1;
         valid_r <= 1'h0;
         echo_t_r <= 1'h0;
         echo_c_r <= 1'h0;
      end else begin
         echo_t_r <= k_s; // [R10]
         echo_c_r <= kn_s; // [R10]
         if (link_edge) begin
            if (rd_hit) begin
               dq_out_r <= mem_r[rd_index]; // [R05]
               oe_n_r <= 1'h0; // [R12]
               valid_r <= 1'h1; // [R11]
            end else begin
               oe_n_r <= 1'h1; // [R12]
               valid_r <= 1'h0; // [R11]
            end
         end
      end
   end

   assign DQ_OUT = dq_out_r;
   assign DQ_OE_N = oe_n_r;
   assign READ_VALID_FLAG = valid_r;
   assign ECHO_CLOCK_TRUE = echo_t_r;
   assign ECHO_CLOCK_COMP = echo_c_r;

   // late-write buffer; a beat offered while it is full is lost, so WR_BUF_READY is a pin
   wire buf_in_valid = link_edge & wr_hit; // [R04] [R06]
   wire buf_in_ready;
   wire buf_out_valid;
   wire [FW-1:0] buf_out_data;
   // drain stalls on link edges so the array never updates while a beat is sampled
   wire buf_out_ready = ~link_edge;

   dbs_fifo #(
      .WIDTH(FW),
      .DEPTH(`DBS_FIFO_DEPTH),
      .AW(`DBS_FIFO_AW)
   ) u_wbuf (
      .clk(CORE_CLK),
      .rst(RESET),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data({wr_index, be_n_s, dq_s}),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   assign WR_BUF_READY = buf_in_ready;

   function [DW-1:0] lane_merge;
      input [DW-1:0] old_w;
      input [DW-1:0] new_w;
      input [LANES-1:0] en_n;
      integer l;
      begin
         lane_merge = old_w;
         for (l = 0; l < LANES; l = l + 1)
            if (!en_n[l])
               lane_merge[l*`DBS_LANE_W +: `DBS_LANE_W] = new_w[l*`DBS_LANE_W +: `DBS_LANE_W]; // [R15]
      end
   endfunction

   wire [MW-1:0] drain_index = buf_out_data[FW-1 -: MW];
   wire [LANES-1:0] drain_be_n = buf_out_data[DW +: LANES];
   wire [DW-1:0] drain_data = buf_out_data[DW-1:0];

   // one word per core cycle, far inside two link cycles
   always @(posedge CORE_CLK) begin
      if (buf_out_valid & buf_out_ready)
         mem_r[drain_index] <= lane_merge(mem_r[drain_index], drain_data, drain_be_n); // [R08] [R06]
   end
endmodule // dbs_sram_port

// ### tb/dbs_sram_port_properties.sv
`timescale 1ns/1ps
module dbs_sram_port_properties #(
   parameter LANES = 4
) (
   input wire CORE_CLK,
   input wire RESET,
   input wire K,
   input wire K_N,
   input wire LOAD_SELECT_N,
   input wire READ_WRITE_SEL,
   input wire [LANES*9-1:0] DQ_OUT,
   input wire DQ_OE_N,
   input wire ECHO_CLOCK_TRUE,
   input wire ECHO_CLOCK_COMP,
   input wire READ_VALID_FLAG
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   property p_oe_valid; DQ_OE_N == !READ_VALID_FLAG; endproperty
   a_oe_valid: assert property (p_oe_valid)
      else $error("bus enable and valid flag disagree");
   property p_reset_state; $fell(RESET) |-> DQ_OE_N && !READ_VALID_FLAG && !ECHO_CLOCK_TRUE; endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("outputs not idle after reset");
   property p_latency; ($rose(K) && !LOAD_SELECT_N && READ_WRITE_SEL) |-> ##[30:38] $rose(READ_VALID_FLAG); endproperty
   a_latency: assert property (p_latency)
      else $error("first read beat late or missing");
   property p_valid_span; $rose(READ_VALID_FLAG) |-> ##[23:27] $fell(READ_VALID_FLAG); endproperty
   a_valid_span: assert property (p_valid_span)
      else $error("read burst not four beats long");
   property p_valid_min; $rose(READ_VALID_FLAG) |-> READ_VALID_FLAG [*8]; endproperty
   a_valid_min: assert property (p_valid_min)
      else $error("read burst ended early");
   property p_beat_stable; (READ_VALID_FLAG && !$stable(DQ_OUT)) |=> $stable(DQ_OUT) [*4]; endproperty
   a_beat_stable: assert property (p_beat_stable)
      else $error("read beat changed within half a link cycle");
   property p_idle_hold; !READ_VALID_FLAG |-> $stable(DQ_OUT); endproperty
   a_idle_hold: assert property (p_idle_hold)
      else $error("read data moved outside a burst");
   property p_echo_true; $rose(K) |-> ##[1:5] $rose(ECHO_CLOCK_TRUE); endproperty
   a_echo_true: assert property (p_echo_true)
      else $error("true echo did not follow the link clock");
   property p_echo_comp; $rose(K_N) |-> ##[1:5] $rose(ECHO_CLOCK_COMP); endproperty
   a_echo_comp: assert property (p_echo_comp)
      else $error("complement echo did not follow the link clock");
   c_read: cover property ($rose(READ_VALID_FLAG));
   c_write: cover property ($rose(K) && !LOAD_SELECT_N && !READ_WRITE_SEL);
   c_echo: cover property ($rose(ECHO_CLOCK_COMP));
endmodule // dbs_sram_port_properties
bind dbs_sram_port dbs_sram_port_properties #(.LANES(LANES)) i_props (.CORE_CLK(CORE_CLK), .RESET(RESET),
   .K(K), .K_N(K_N), .LOAD_SELECT_N(LOAD_SELECT_N), .READ_WRITE_SEL(READ_WRITE_SEL), .DQ_OUT(DQ_OUT),
   .DQ_OE_N(DQ_OE_N), .ECHO_CLOCK_TRUE(ECHO_CLOCK_TRUE), .ECHO_CLOCK_COMP(ECHO_CLOCK_COMP),
   .READ_VALID_FLAG(READ_VALID_FLAG));

// ### tb/dbs_ctrl_model.sv
`timescale 1ns/1ps
module dbs_ctrl_model (
   input wire CORE_CLK,
   output logic K,
   output wire K_N,
   output logic LOAD_SELECT_N,
   output logic READ_WRITE_SEL,
   output logic [3:0] ADDR,
   output logic [3:0] BYTE_LANE_ENABLE_N,
   output logic [35:0] DQ_DRV
);
   realtime t_cmd;
   assign K_N = ~K;
   initial begin
      K = 1'b0;
      LOAD_SELECT_N = 1'b1;
      READ_WRITE_SEL = 1'b0;
      ADDR = 4'h0;
      BYTE_LANE_ENABLE_N = 4'hf;
      DQ_DRV = 36'h0_0000_0000;
      // offset keeps link edges off both core clock edges
      #1;
      forever #62.5 K = ~K;
   end
   // one op at a time, so commands are always two or more K cycles apart
   task automatic cmd(input logic rd, input logic [3:0] a);
      @(negedge K);
      @(negedge CORE_CLK);
      LOAD_SELECT_N = 1'b0;
      READ_WRITE_SEL = rd;
      ADDR = a;
      @(posedge K);
      t_cmd = $realtime;
      @(negedge K);
      @(negedge CORE_CLK);
      LOAD_SELECT_N = 1'b1;
      ADDR = ~a;
   endtask
   // data changes mid-beat, far from the capturing edge
   task automatic write(input logic [3:0] a, input logic [3:0][35:0] d, input logic [3:0][3:0] en);
      cmd(1'b0, a);
      for (int b = 0; b < 4; b++) begin
         repeat (b ? 3 : 2) @(negedge CORE_CLK);
         DQ_DRV = d[b];
         BYTE_LANE_ENABLE_N = en[b];
         @(K);
      end
      repeat (3) @(negedge CORE_CLK);
      DQ_DRV = ~DQ_DRV;
      BYTE_LANE_ENABLE_N = ~BYTE_LANE_ENABLE_N;
   endtask
endmodule // dbs_ctrl_model

// ### tb/tb_dbs_sram_port.sv
`timescale 1ns/1ps
module tb_dbs_sram_port;
   logic CORE_CLK;
   logic RESET = 1'b1;
   wire k, k_n, ld_n, rw, oe_n, echo_t, echo_c, valid, wbr;
   wire [3:0] addr, ben_n;
   wire [35:0] drv, dq_out, dq_in;
   logic [35:0] mem [16][4];
   int bad_count = 0;
   int cmp_count = 0;
   assign dq_in = oe_n ? drv : dq_out;
   dbs_ctrl_model i_ctrl (.CORE_CLK(CORE_CLK), .K(k), .K_N(k_n), .LOAD_SELECT_N(ld_n), .READ_WRITE_SEL(rw),
      .ADDR(addr), .BYTE_LANE_ENABLE_N(ben_n), .DQ_DRV(drv));
   dbs_sram_port i_dut (.CORE_CLK(CORE_CLK), .RESET(RESET), .K(k), .K_N(k_n), .LOAD_SELECT_N(ld_n),
      .READ_WRITE_SEL(rw), .ADDR(addr), .BYTE_LANE_ENABLE_N(ben_n), .DQ_IN(dq_in), .DQ_OUT(dq_out),
      .DQ_OE_N(oe_n), .ECHO_CLOCK_TRUE(echo_t), .ECHO_CLOCK_COMP(echo_c), .READ_VALID_FLAG(valid),
      .WR_BUF_READY(wbr));
   initial begin
      CORE_CLK = 1'b0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end
   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input int a, input int s, input logic [3:0][3:0] en);
      logic [3:0][35:0] d;
      for (int b = 0; b < 4; b++) begin
         d[b] = 36'(36'h1_2345_6789 * (a * 4 + b + 8 * s + 1));
         for (int l = 0; l < 4; l++)
            if (!en[b][l]) mem[a][b][l*9+:9] = d[b][l*9+:9];
      end
      i_ctrl.write(4'(a), d, en);
   endtask
   task automatic rd(input int a);
      realtime dt;
      i_ctrl.cmd(1'b1, 4'(a));
      for (int n = 0; n < 60 && valid !== 1'b1; n++) @(negedge CORE_CLK);
      dt = $realtime - i_ctrl.t_cmd;
      chk("first beat delay", 36'h0_0000_0001, 36'(dt > 325.0 && dt < 372.0));
      for (int b = 0; b < 4; b++) begin
         if (b) @(k);
         repeat (b ? 6 : 2) @(negedge CORE_CLK);
         chk("read beat", mem[a][b], dq_out);
         chk("bus enable", 36'h0_0000_0000, 36'(oe_n));
         chk("valid flag", 36'h0_0000_0001, 36'(valid));
      end
      @(k);
      repeat (6) @(negedge CORE_CLK);
      chk("valid after burst", 36'h0_0000_0000, 36'(valid));
      chk("bus released", 36'h0_0000_0001, 36'(oe_n));
   endtask
   task automatic t_reset;
      chk("idle read data", 36'h0_0000_0000, dq_out);
      chk("idle bus enable", 36'h0_0000_0001, 36'(oe_n));
      chk("idle valid", 36'h0_0000_0000, 36'(valid));
      chk("buffer ready", 36'h0_0000_0001, 36'(wbr));
   endtask
   task automatic t_write_read;
      wr(0, 0, 16'h0000);
      wr(15, 0, 16'h0000);
      rd(0);
      rd(15);
   endtask
   task automatic t_lanes;
      // per-beat masks cover all lanes, alternate lanes and none
      wr(15, 1, {4'hf, 4'ha, 4'h5, 4'h0});
      rd(15);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      report_and_stop;
   end
   initial begin
      repeat (5) @(negedge CORE_CLK);
      RESET = 1'b0;
      t_reset;
      t_write_read;
      t_lanes;
      report_and_stop;
   end
endmodule // tb_dbs_sram_port
